/* pkg/fcs_pkg.sv */
// package for the feedback control/status register bank
// assumes an axi4-lite host at 32-bit data, register index times four is the byte address
`default_nettype none
package fcs_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [11:0] IDX_MAIN_CONTROL   = 12'h100;
  localparam logic [11:0] IDX_STICKY_STATUS  = 12'h101;
  localparam logic [11:0] IDX_PHASE_SHIFT    = 12'h102;
  localparam logic [11:0] IDX_OUT_DELAY      = 12'h104;
  localparam logic [11:0] IDX_GROWTH_LENGTH  = 12'h105;
  localparam logic [11:0] IDX_HOLDOFF_LENGTH = 12'h106;
  localparam logic [11:0] IDX_BUILD_CONFIG   = 12'h107;
  localparam logic [11:0] IDX_FIDUCIAL_DELAY = 12'h108;
  localparam logic [11:0] IDX_ACQ_LENGTH     = 12'h109;
  localparam logic [11:0] IDX_ACQ_DONE       = 12'h200;
  localparam logic [11:0] IDX_TEST_START     = 12'h201;
  localparam logic [11:0] IDX_DECIMATED_MEAN = 12'h202;
  localparam int ADDR_W = 14;
  // control bit positions
  localparam int CB_SOFT_TRIG   = 0;
  localparam int CB_TRIG_SEL1   = 1;
  localparam int CB_SET_SEL     = 2;
  localparam int CB_FILT_DIS    = 3;
  localparam int CB_GAIN_LO     = 4;
  localparam int CB_CLKMGR_RST  = 7;
  localparam int CB_GROWDAMP_EN = 8;
  localparam int CB_EXT_TRIG    = 9;
  localparam int CB_ARM         = 10;
  localparam int CB_MEM_ADC     = 11;
  localparam int CB_TEST_EN     = 12;
  localparam int CB_PHASE_INV   = 13;
  localparam int CB_FAST_DRV    = 16;
  // writable masks, reserved bits read zero
  localparam logic [31:0] MASK_CONTROL  = 32'h0001_3fff;
  localparam logic [31:0] MASK_STATUS   = 32'h0000_00ff;
  localparam logic [31:0] MASK_PHASE    = 32'h0000_01ff;
  localparam logic [31:0] MASK_OUTDLY   = 32'h0f1f_ffff;
  localparam logic [31:0] MASK_LEN22    = 32'h003f_ffff;
  localparam logic [31:0] MASK_FIDDLY   = 32'h0000_0fff;
  localparam logic [31:0] RESET_ZERO    = 32'h0000_0000;
  localparam int ST_ARMED = 3;
  // build configuration defaults; revision and function code values are arbitrary
  localparam logic [12:0] DEF_HARMONIC  = 13'h0001;
  localparam logic [1:0]  DEF_DEMUX     = 2'h0;
  localparam logic [7:0]  DEF_REVISION  = 8'h01;
  localparam logic [7:0]  DEF_FUNCTION  = 8'h5a;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // outward control word
  typedef struct packed {
    logic        trigSelOne;
    logic        coefSet;
    logic        filterOff;
    logic [2:0]  shiftGain;
    logic        clockManagerReset;
    logic        externalTrigger;
    logic        memToConverter;
    logic        testPatternEnable;
    logic        phaseInvert;
    logic        fastDriverSelect;
  } fcs_ctrl_type;
  typedef struct packed {
    logic [10:0] outputDelay;
    logic [4:0]  recordDownsample;
    logic [4:0]  procDownsample;
    logic [3:0]  fineDelay;
    logic [11:0] fiducialDelay;
    logic [8:0]  phaseShift;
  } fcs_timing_type;
  typedef enum logic [1:0] {GD_IDLE, GD_HOLDOFF, GD_ACQUIRE} fcs_acq_type;
endpackage
`default_nettype wire

/* rtl/fcs_regs.sv */
// feedback control/status register bank with grow/damp acquisition sequencer
// assumes one 125 MHz clock, synchronous status events and a sample-group tick
`timescale 1ns/1ps
`default_nettype none
module fcs_regs
  import fcs_pkg::*;
#(
  parameter logic [12:0] HARMONIC = DEF_HARMONIC,
  parameter logic [1:0]  DEMUX    = DEF_DEMUX,
  parameter logic [7:0]  REVISION = DEF_REVISION,
  parameter logic [7:0]  FUNCTION = DEF_FUNCTION
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              nrst,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output var  logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output var  logic              wready,
  output var  logic [1:0]        bresp,
  output var  logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output var  logic              arready,
  output var  logic [31:0]       rdata,
  output var  logic [1:0]        rresp,
  output var  logic              rvalid,
  input  wire logic              rready,
  // status events, one per status bit; the arming bit is also set while armed
  input  wire logic [7:0]        statusEvent,
  // acquisition side
  input  wire logic              triggerInputOne,
  input  wire logic              triggerInputTwo,
  input  wire logic              groupTick,
  input  wire logic [31:0]       decimatedMean,
  // control outputs
  output var  fcs_ctrl_type      ctrl,
  output var  fcs_timing_type    timing,
  output var  logic [31:0]       testStart,
  output var  logic              activeCoefSet,
  output var  logic              acquiring,
  output var  logic              acqDone
);
  logic [31:0] mainControl, stickyStatus, outDelay, growthLength;
  logic [31:0] holdoffLength, fiducialDelay, acqLength, phaseShift;
  logic [ADDR_W-1:0] wAddr;
  logic wAddrHeld, wDataHeld, armed, armPrev, trigPrev;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic [31:0] groupCount;
  fcs_acq_type acqState;
  logic doWrite, doRead, trigger, trigSel, trigEdge;
  logic [31:0] next_readData;
  logic        next_readOk;

  function automatic logic [11:0] regIndex(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s, input logic [31:0] m);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r & m;
  endfunction
  function automatic logic writeOk(input logic [11:0] i);
    return i == IDX_MAIN_CONTROL || i == IDX_PHASE_SHIFT || i == IDX_OUT_DELAY ||
           i == IDX_GROWTH_LENGTH || i == IDX_HOLDOFF_LENGTH || i == IDX_FIDUCIAL_DELAY ||
           i == IDX_ACQ_LENGTH || i == IDX_TEST_START;
  endfunction

  // write address and data are accepted in either order
  assign doWrite = wAddrHeld && wDataHeld && !bvalid;
  assign doRead  = arvalid && arready;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      awready   <= 1'b0;
      wready    <= 1'b0;
      wAddrHeld <= 1'b0;
      wDataHeld <= 1'b0;
      wAddr     <= '0;
      wData     <= '0;
      wStrb     <= '0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end else begin
      awready <= !wAddrHeld && !(awvalid && awready) && !bvalid;
      wready  <= !wDataHeld && !(wvalid && wready) && !bvalid;
      if (awvalid && awready) begin
        wAddrHeld <= 1'b1;
        wAddr     <= awaddr;
      end
      if (wvalid && wready) begin
        wDataHeld <= 1'b1;
        wData     <= wdata;
        wStrb     <= wstrb;
      end
      if (doWrite) begin
        bvalid    <= 1'b1;
        wAddrHeld <= 1'b0;
        wDataHeld <= 1'b0;
        bresp     <= writeOk(regIndex(wAddr)) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // writable registers; reserved bits held at zero by masks
  always_ff @(posedge clock) begin
    if (!nrst) begin
      mainControl   <= RESET_ZERO;
      phaseShift    <= RESET_ZERO;
      outDelay      <= RESET_ZERO;
      growthLength  <= RESET_ZERO;
      holdoffLength <= RESET_ZERO;
      fiducialDelay <= RESET_ZERO;
      acqLength     <= RESET_ZERO;
      testStart     <= RESET_ZERO;
    end else if (doWrite) begin
      if (regIndex(wAddr) == IDX_MAIN_CONTROL) begin
        mainControl <= merge(mainControl, wData, wStrb, MASK_CONTROL);
      end else if (regIndex(wAddr) == IDX_PHASE_SHIFT) begin
        phaseShift <= merge(phaseShift, wData, wStrb, MASK_PHASE);
      end else if (regIndex(wAddr) == IDX_OUT_DELAY) begin
        outDelay <= merge(outDelay, wData, wStrb, MASK_OUTDLY);
      end else if (regIndex(wAddr) == IDX_GROWTH_LENGTH) begin
        growthLength <= merge(growthLength, wData, wStrb, MASK_LEN22);
      end else if (regIndex(wAddr) == IDX_HOLDOFF_LENGTH) begin
        holdoffLength <= merge(holdoffLength, wData, wStrb, '1);
      end else if (regIndex(wAddr) == IDX_FIDUCIAL_DELAY) begin
        fiducialDelay <= merge(fiducialDelay, wData, wStrb, MASK_FIDDLY);
      end else if (regIndex(wAddr) == IDX_ACQ_LENGTH) begin
        acqLength <= merge(acqLength, wData, wStrb, MASK_LEN22);
      end else if (regIndex(wAddr) == IDX_TEST_START) begin
        testStart <= merge(testStart, wData, wStrb, '1);
      end
    end
  end

  // read mux
  always_comb begin
    next_readData = RESET_ZERO;
    next_readOk   = 1'b1;
    if (regIndex(araddr) == IDX_MAIN_CONTROL) begin
      next_readData = mainControl;
    end else if (regIndex(araddr) == IDX_STICKY_STATUS) begin
      next_readData = stickyStatus;
    end else if (regIndex(araddr) == IDX_PHASE_SHIFT) begin
      next_readData = phaseShift;
    end else if (regIndex(araddr) == IDX_OUT_DELAY) begin
      next_readData = outDelay;
    end else if (regIndex(araddr) == IDX_GROWTH_LENGTH) begin
      next_readData = growthLength;
    end else if (regIndex(araddr) == IDX_HOLDOFF_LENGTH) begin
      next_readData = holdoffLength;
    end else if (regIndex(araddr) == IDX_BUILD_CONFIG) begin
      next_readData = {FUNCTION, REVISION, 1'b0, DEMUX, HARMONIC};
    end else if (regIndex(araddr) == IDX_FIDUCIAL_DELAY) begin
      next_readData = fiducialDelay;
    end else if (regIndex(araddr) == IDX_ACQ_LENGTH) begin
      next_readData = acqLength;
    end else if (regIndex(araddr) == IDX_ACQ_DONE) begin
      next_readData = {31'h0, acqDone};
    end else if (regIndex(araddr) == IDX_TEST_START) begin
      next_readData = testStart;
    end else if (regIndex(araddr) == IDX_DECIMATED_MEAN) begin
      next_readData = decimatedMean;
    end else begin
      next_readOk = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= RESET_ZERO;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= !rvalid && !(arvalid && arready);
      if (doRead) begin
        rvalid <= 1'b1;
        rdata  <= next_readData;
        rresp  <= next_readOk ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      armPrev <= 1'b0;
      armed   <= 1'b0;
    end else begin
      armPrev <= mainControl[CB_ARM];
      if (mainControl[CB_ARM] && !armPrev) begin
        armed <= 1'b1;
      end else if (trigEdge && mainControl[CB_EXT_TRIG]) begin
        armed <= 1'b0;
      end
    end
  end

  // sticky flags, a new event wins over the read clear
  always_ff @(posedge clock) begin
    if (!nrst) begin
      stickyStatus <= RESET_ZERO;
    end else begin
      stickyStatus <= ((doRead && regIndex(araddr) == IDX_STICKY_STATUS) ? RESET_ZERO : stickyStatus)
                      | ({24'h0, statusEvent} & MASK_STATUS)
                      | (32'h1 << ST_ARMED & {32{armed}});
    end
  end

  assign trigSel = mainControl[CB_TRIG_SEL1] ? triggerInputOne : triggerInputTwo;
  assign trigEdge = trigSel && !trigPrev;
  assign trigger = mainControl[CB_EXT_TRIG] ? (trigEdge && armed) : mainControl[CB_SOFT_TRIG];

  always_ff @(posedge clock) begin
    if (!nrst) begin
      trigPrev <= 1'b0;
    end else begin
      trigPrev <= trigSel;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      acqState   <= GD_IDLE;
      groupCount <= RESET_ZERO;
      acqDone    <= 1'b0;
    end else begin
      case (acqState)
        GD_IDLE: begin
          if (trigger) begin
            acqDone    <= 1'b0;
            groupCount <= RESET_ZERO;
            acqState   <= (mainControl[CB_GROWDAMP_EN] && holdoffLength != 0) ? GD_HOLDOFF : GD_ACQUIRE;
          end
        end
        GD_HOLDOFF: begin
          if (groupTick) begin
            if (groupCount == holdoffLength - 32'h1) begin
              groupCount <= RESET_ZERO;
              acqState   <= GD_ACQUIRE;
            end else begin
              groupCount <= groupCount + 32'h1;
            end
          end
        end
        GD_ACQUIRE: begin
          if (groupTick) begin
            if (groupCount + 32'h1 >= acqLength) begin
              acqDone  <= 1'b1;
              acqState <= GD_IDLE;
            end else begin
              groupCount <= groupCount + 32'h1;
            end
          end
        end
        default: acqState <= GD_IDLE;
      endcase
    end
  end

  // control outputs, registered
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctrl          <= '0;
      timing        <= '0;
      activeCoefSet <= 1'b0;
      acquiring     <= 1'b0;
    end else begin
      ctrl.trigSelOne        <= mainControl[CB_TRIG_SEL1];
      ctrl.coefSet           <= mainControl[CB_SET_SEL];
      ctrl.filterOff         <= mainControl[CB_FILT_DIS];
      ctrl.shiftGain         <= mainControl[CB_GAIN_LO +: 3];
      ctrl.clockManagerReset <= mainControl[CB_CLKMGR_RST];
      ctrl.externalTrigger   <= mainControl[CB_EXT_TRIG];
      ctrl.memToConverter    <= mainControl[CB_MEM_ADC];
      ctrl.testPatternEnable <= mainControl[CB_TEST_EN];
      ctrl.phaseInvert       <= mainControl[CB_PHASE_INV];
      ctrl.fastDriverSelect  <= mainControl[CB_FAST_DRV];
      timing.outputDelay      <= outDelay[10:0];
      timing.recordDownsample <= outDelay[15:11];
      timing.procDownsample   <= outDelay[20:16];
      timing.fineDelay        <= outDelay[27:24];
      timing.fiducialDelay    <= fiducialDelay[11:0];
      timing.phaseShift       <= phaseShift[8:0];
      activeCoefSet <= mainControl[CB_SET_SEL] ^ (mainControl[CB_GROWDAMP_EN] &&
                       (acqState == GD_HOLDOFF ||
                        (acqState == GD_ACQUIRE && groupCount < growthLength)));
      acquiring <= acqState == GD_ACQUIRE;
    end
  end

  a_status_clear: assert property (@(posedge clock) disable iff (!nrst)
    doRead && regIndex(araddr) == IDX_STICKY_STATUS && statusEvent == 0 && !armed |=> stickyStatus == 0)
    else $error("status not cleared by read");
  a_status_sticky: assert property (@(posedge clock) disable iff (!nrst)
    statusEvent[0] |=> stickyStatus[0])
    else $error("status event lost");
  a_arm_edge: assert property (@(posedge clock) disable iff (!nrst)
    $rose(armed) |-> $past(mainControl[CB_ARM]) && !$past(armPrev))
    else $error("arm without rising edge");
  a_phase_upper: assert property (@(posedge clock) disable iff (!nrst)
    phaseShift[31:9] == 0)
    else $error("phase upper bits nonzero");
  a_done_clear: assert property (@(posedge clock) disable iff (!nrst)
    acqState == GD_IDLE && trigger |=> !acqDone)
    else $error("done not cleared by trigger");
  a_gain_out: assert property (@(posedge clock) disable iff (!nrst)
    1'b1 |=> ctrl.shiftGain == $past(mainControl[6:4]))
    else $error("shift gain mismatch");
  a_coef_set: assert property (@(posedge clock) disable iff (!nrst)
    !mainControl[CB_GROWDAMP_EN] |=> activeCoefSet == $past(mainControl[CB_SET_SEL]))
    else $error("coefficient set mismatch");
  a_holdoff_invert: assert property (@(posedge clock) disable iff (!nrst)
    acqState == GD_HOLDOFF && mainControl[CB_GROWDAMP_EN] |=> activeCoefSet != $past(mainControl[CB_SET_SEL]))
    else $error("holdoff not inverted");
  a_drive_phase: assert property (@(posedge clock) disable iff (!nrst)
    1'b1 |=> ctrl.phaseInvert == $past(mainControl[CB_PHASE_INV]))
    else $error("drive phase mismatch");
  a_build_ro: assert property (@(posedge clock) disable iff (!nrst)
    doRead && regIndex(araddr) == IDX_BUILD_CONFIG |=> rdata[31:24] == FUNCTION && rdata[12:0] == HARMONIC)
    else $error("build word wrong");
  c_write: cover property (@(posedge clock) disable iff (!nrst) doWrite);
  c_status_read: cover property (@(posedge clock) disable iff (!nrst)
    doRead && regIndex(araddr) == IDX_STICKY_STATUS && stickyStatus != 0);
  c_holdoff: cover property (@(posedge clock) disable iff (!nrst) acqState == GD_HOLDOFF);
  c_done: cover property (@(posedge clock) disable iff (!nrst) $rose(acqDone));
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// self-checking bench for the feedback control/status register bank
// assumes the bank alone sits on an axi4-lite bus mastered from here, 125 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fcs_pkg::*;
  localparam logic [12:0] HARM = 13'h0a2b;
  localparam logic [1:0]  DMX  = 2'h3;
  logic              clock       = 1'b0;
  logic              nrst        = 1'b0;
  logic [ADDR_W-1:0] awaddr      = '0;
  logic [ADDR_W-1:0] araddr      = '0;
  logic              awvalid     = 1'b0;
  logic              wvalid      = 1'b0;
  logic              bready      = 1'b0;
  logic              arvalid     = 1'b0;
  logic              rready      = 1'b0;
  logic              groupTick   = 1'b0;
  logic              trigOne     = 1'b0;
  logic              trigTwo     = 1'b0;
  logic [31:0]       wdata       = '0;
  logic [31:0]       mean        = '0;
  logic [3:0]        wstrb       = 4'hf;
  logic [7:0]        statusEvent = '0;
  logic              awready, wready, bvalid, arready, rvalid, activeCoefSet, acquiring, acqDone;
  logic [1:0]        bresp, rresp;
  logic [31:0]       rdata, testStart, v, w;
  fcs_ctrl_type      ctrl;
  fcs_timing_type    timing;
  logic [33:0]       expQ[$];
  logic [33:0]       got;
  int                mismatches = 0;
  int                testsRun   = 0;
  int                cycles     = 0;
  logic [11:0] idxs[6]  = '{IDX_PHASE_SHIFT, IDX_OUT_DELAY, IDX_GROWTH_LENGTH, IDX_HOLDOFF_LENGTH,
                            IDX_FIDUCIAL_DELAY, IDX_ACQ_LENGTH};
  logic [31:0] masks[6] = '{MASK_PHASE, MASK_OUTDLY, MASK_LEN22, 32'hffff_ffff, MASK_FIDDLY, MASK_LEN22};

  fcs_regs #(.HARMONIC(HARM), .DEMUX(DMX)) uut (
    .clock(clock), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .statusEvent(statusEvent),
    .triggerInputOne(trigOne), .triggerInputTwo(trigTwo), .groupTick(groupTick),
    .decimatedMean(mean), .ctrl(ctrl), .timing(timing), .testStart(testStart),
    .activeCoefSet(activeCoefSet), .acquiring(acquiring), .acqDone(acqDone));

  initial begin
    forever #4 clock = ~clock;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    testsRun++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finalReport();
    if (mismatches == 0 && testsRun > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // address and data offered together, each released at its own handshake
  task automatic wr(input logic [11:0] idx, input logic [31:0] d, input logic [1:0] r);
    expQ.push_back({r, 32'h0});
    @(posedge clock);
    awaddr  <= {idx, 2'b00};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] idx, input logic [31:0] d, input logic [1:0] r);
    expQ.push_back({r, d});
    @(posedge clock);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask

  // one group pulse, then let registered outputs settle
  task automatic tick();
    @(posedge clock);
    groupTick <= 1'b1;
    @(posedge clock);
    groupTick <= 1'b0;
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask

  function automatic fcs_ctrl_type ctrlOf(input logic [31:0] c);
    ctrlOf = '{c[1], c[2], c[3], c[6:4], c[7], c[9], c[11], c[12], c[13], c[16]};
  endfunction

  // responses are compared in arrival order; one transfer at a time keeps the queue aligned
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (nrst && ((bvalid && bready) || (rvalid && rready))) begin
      got = (rvalid && rready) ? {rresp, rdata} : {bresp, 32'h0};
      if (expQ.size() == 0) check(64'(got), 64'h1_0000_0000);
      else check(64'(got), 64'(expQ.pop_front()));
    end
    if (cycles == 20000) begin
      mismatches++;
      finalReport();
    end
  end

  initial begin
    v = $urandom(31700);
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    // soft trigger, arming and grow/damp bits kept clear here so no acquisition starts
    for (int i = 0; i < 6; i++) begin
      v = ((i == 0) ? MASK_CONTROL : $urandom()) & MASK_CONTROL & ~32'h0000_0501;
      wr(IDX_MAIN_CONTROL, v, RESP_OKAY);
      rd(IDX_MAIN_CONTROL, v, RESP_OKAY);
      @(negedge clock);
      check(64'(ctrl), 64'(ctrlOf(v)));
      check(64'(activeCoefSet), 64'(v[CB_SET_SEL]));
    end
    foreach (idxs[i]) begin
      wr(idxs[i], 32'hffff_ffff, RESP_OKAY);
      rd(idxs[i], masks[i], RESP_OKAY);
    end
    v = $urandom();
    w = $urandom();
    wr(IDX_OUT_DELAY, v, RESP_OKAY);
    wr(IDX_FIDUCIAL_DELAY, w, RESP_OKAY);
    wr(IDX_PHASE_SHIFT, w, RESP_OKAY);
    @(negedge clock);
    check(64'(timing), 64'({v[10:0], v[15:11], v[20:16], v[27:24], w[11:0], w[8:0]}));
    wr(IDX_TEST_START, v, RESP_OKAY);
    rd(IDX_TEST_START, v, RESP_OKAY);
    check(64'(testStart), 64'(v));
    // byte strobes: only byte one may change
    wstrb <= 4'h2;
    wr(IDX_TEST_START, 32'hffff_ffff, RESP_OKAY);
    wstrb <= 4'hf;
    rd(IDX_TEST_START, v | 32'h0000_ff00, RESP_OKAY);
    rd(IDX_BUILD_CONFIG, {DEF_FUNCTION, DEF_REVISION, 1'b0, DMX, HARM}, RESP_OKAY);
    wr(IDX_BUILD_CONFIG, 32'h0, RESP_SLVERR);
    rd(IDX_BUILD_CONFIG, {DEF_FUNCTION, DEF_REVISION, 1'b0, DMX, HARM}, RESP_OKAY);
    rd(12'h103, 32'h0, RESP_SLVERR);
    wr(12'h103, v, RESP_SLVERR);
    @(posedge clock);
    mean <= w;
    rd(IDX_DECIMATED_MEAN, w, RESP_OKAY);
    // sticky flags cleared by a read
    rd(IDX_STICKY_STATUS, 32'h0, RESP_OKAY);
    @(posedge clock);
    statusEvent <= v[7:0] | 8'h01;
    @(posedge clock);
    statusEvent <= '0;
    rd(IDX_STICKY_STATUS, {24'h0, v[7:0] | 8'h01}, RESP_OKAY);
    rd(IDX_STICKY_STATUS, 32'h0, RESP_OKAY);
    // armed external trigger on input one
    wr(IDX_ACQ_LENGTH, 32'h3, RESP_OKAY);
    wr(IDX_HOLDOFF_LENGTH, 32'h0, RESP_OKAY);
    wr(IDX_GROWTH_LENGTH, 32'h0, RESP_OKAY);
    wr(IDX_MAIN_CONTROL, 32'h0000_0602, RESP_OKAY);
    rd(IDX_STICKY_STATUS, 32'h8, RESP_OKAY);
    rd(IDX_STICKY_STATUS, 32'h8, RESP_OKAY);
    @(posedge clock);
    trigTwo <= 1'b1;
    repeat (3) @(posedge clock);
    @(negedge clock);
    check(64'(acquiring), 64'h0);
    @(posedge clock);
    trigOne <= 1'b1;
    repeat (3) @(posedge clock);
    @(negedge clock);
    check(64'(acquiring), 64'h1);
    rd(IDX_STICKY_STATUS, 32'h8, RESP_OKAY);
    wr(IDX_MAIN_CONTROL, 32'h0000_0602, RESP_OKAY);
    rd(IDX_STICKY_STATUS, 32'h0, RESP_OKAY);
    repeat (2) tick();
    check(64'(acqDone), 64'h0);
    tick();
    check(64'(acqDone), 64'h1);
    rd(IDX_ACQ_DONE, 32'h1, RESP_OKAY);
    wr(IDX_HOLDOFF_LENGTH, 32'h2, RESP_OKAY);
    wr(IDX_GROWTH_LENGTH, 32'h1, RESP_OKAY);
    wr(IDX_ACQ_LENGTH, 32'h2, RESP_OKAY);
    wr(IDX_MAIN_CONTROL, 32'h0000_0101, RESP_OKAY);
    wr(IDX_MAIN_CONTROL, 32'h0000_0100, RESP_OKAY);
    @(negedge clock);
    check(64'(acqDone), 64'h0);
    check(64'(activeCoefSet), 64'h1);
    repeat (2) tick();
    check(64'(activeCoefSet), 64'h1);
    tick();
    check(64'(activeCoefSet), 64'h0);
    tick();
    check(64'(acqDone), 64'h1);
    repeat (4) @(posedge clock);
    finalReport();
  end
endmodule
`default_nettype wire
